// file: logic/tivc_top.sv
`timescale 1ns/100ps
module tivc_top #(
    parameter int TICK_CYCLES = tivc_pkg::TICK_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire tivc_pkg::tivc_sfr_req_t sfr_req,
    output logic [7:0]                   sfr_rdata,
    input  wire logic                    int_enable,
    input  wire logic                    power_down,
    output logic                         irq,
    output logic                         wake,
    output logic [15:0]                  wake_vector
);
    import tivc_pkg::*;

    localparam logic [PRESC_W-1:0] TICK_LAST = PRESC_W'(TICK_CYCLES - 1);

    tivc_ctrl_t         ctrl_reg;
    tivc_ctrl_t         ctrl_next;
    tivc_time_t         time_reg;
    tivc_time_t         time_next;
    logic [PRESC_W-1:0] presc_reg;
    logic [PRESC_W-1:0] presc_next;
    logic [7:0]         long_period_counter_reg;
    logic [7:0]         long_period_counter_next;
    logic [7:0]         interval_limit_reg;
    logic [7:0]         interval_limit_next;
    logic [7:0]         rdata_reg;
    logic [7:0]         rdata_next;

    logic               wr_ctrl;
    logic               tk_off;
    logic               tick;
    logic               frac_ovf;
    logic               sec_ovf;
    logic               min_ovf;
    logic               sel_roll;
    logic [7:0]         count_inc;
    logic               timeout;

    assign wr_ctrl = sfr_req.wr && (sfr_req.addr == ADDR_CTRL);
    // Falling edge of timekeeping enable, caused by a control write
    assign tk_off  = wr_ctrl && ctrl_reg.timekeeping_enable && !sfr_req.wdata[0];

    // Prescaler runs only with timekeeping on, so ticks stop with it
    assign tick     = ctrl_reg.timekeeping_enable && (presc_reg == TICK_LAST);
    assign frac_ovf = tick && (time_reg.fraction_tick_count == FRAC_MAX);
    assign sec_ovf  = frac_ovf && (time_reg.one_hz_count == SEC_MAX);
    assign min_ovf  = sec_ovf && (time_reg.minutes == MIN_MAX);

    always_comb begin
        presc_next = presc_reg;
        time_next  = time_reg;
        if (ctrl_reg.timekeeping_enable) begin
            presc_next = tick ? '0 : presc_reg + PRESC_W'(1);
            if (tick) begin
                time_next.fraction_tick_count = frac_ovf ? 7'h00 :
                    time_reg.fraction_tick_count + 7'h01;
            end
            if (frac_ovf) begin
                time_next.one_hz_count = sec_ovf ? 6'h00 :
                    time_reg.one_hz_count + 6'h01;
            end
            if (sec_ovf) begin
                time_next.minutes = min_ovf ? 6'h00 : time_reg.minutes + 6'h01;
            end
            if (min_ovf) begin
                time_next.hours = (time_reg.hours == HOUR_MAX) ? 5'h00 :
                    time_reg.hours + 5'h01;
            end
        end else begin
            presc_next = '0;
            // Preset of the current time is only possible while stopped
            if (sfr_req.wr) begin
                unique case (sfr_req.addr)
                    ADDR_FRAC: time_next.fraction_tick_count = sfr_req.wdata[6:0];
                    ADDR_SEC:  time_next.one_hz_count = sfr_req.wdata[5:0];
                    ADDR_MIN:  time_next.minutes = sfr_req.wdata[5:0];
                    ADDR_HOUR: time_next.hours = sfr_req.wdata[4:0];
                    default: ;
                endcase
            end
        end
        if (tk_off) begin
            presc_next = '0;
            time_next  = '0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            presc_reg <= '0;
            time_reg  <= '0;
        end else begin
            presc_reg <= presc_next;
            time_reg  <= time_next;
        end
    end

    // Slowest choice is hours, giving up to 256 hours with a limit of zero
    always_comb begin
        unique case (ctrl_reg.timebase_select)
            SEL_FRACTION: sel_roll = tick;
            SEL_SECONDS:  sel_roll = frac_ovf;
            SEL_MINUTES:  sel_roll = sec_ovf;
            SEL_HOURS:    sel_roll = min_ovf;
        endcase
    end

    assign count_inc = long_period_counter_reg + 8'h01;
    // A limit of zero matches only when the counter wraps past 255
    assign timeout   = ctrl_reg.interval_enable && sel_roll &&
                       (count_inc == interval_limit_reg);

    always_comb begin
        long_period_counter_next = long_period_counter_reg;
        if (!ctrl_reg.interval_enable) begin
            long_period_counter_next = 8'h00;
        end else if (sel_roll) begin
            long_period_counter_next = timeout ? 8'h00 : count_inc;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            long_period_counter_reg <= 8'h00;
        end else begin
            long_period_counter_reg <= long_period_counter_next;
        end
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            // Bits 7 and 6 are not stored
            ctrl_next = tivc_ctrl_t'(sfr_req.wdata[CTRL_BITS-1:0]);
        end
        if (timeout) begin
            // Set wins over a software clear in the same cycle
            ctrl_next.interval_match_flag = 1'b1;
            if (ctrl_reg.single_interval) begin
                ctrl_next.interval_enable = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= tivc_ctrl_t'(CTRL_RESET);
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_comb begin
        interval_limit_next = interval_limit_reg;
        if (sfr_req.wr && (sfr_req.addr == ADDR_LIMIT)) begin
            interval_limit_next = sfr_req.wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            interval_limit_reg <= LIMIT_RESET;
        end else begin
            interval_limit_reg <= interval_limit_next;
        end
    end

    always_comb begin
        unique case (sfr_req.addr)
            ADDR_CTRL:  rdata_next = {2'b00, ctrl_reg};
            ADDR_FRAC:  rdata_next = {1'b0, time_reg.fraction_tick_count};
            ADDR_SEC:   rdata_next = {2'b00, time_reg.one_hz_count};
            ADDR_MIN:   rdata_next = {2'b00, time_reg.minutes};
            ADDR_HOUR:  rdata_next = {3'b000, time_reg.hours};
            ADDR_LIMIT: rdata_next = interval_limit_reg;
            default:    rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign sfr_rdata   = rdata_reg;
    assign irq         = ctrl_reg.interval_match_flag && int_enable;
    // Flag is level, so a wake request holds until software clears it or int_enable or power_down drops
    assign wake        = irq && power_down;
    assign wake_vector = WAKE_VECTOR;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_match_sets_flag: assert property (timeout |=> ctrl_reg.interval_match_flag)
        else $error("match did not set flag");

    a_irq_on_flag: assert property (
        ctrl_reg.interval_match_flag && int_enable |-> irq && wake_vector == 16'h0053)
        else $error("irq missing with flag and enable");

    a_wake_power_down: assert property (
        $rose(ctrl_reg.interval_match_flag) && int_enable && power_down |-> wake)
        else $error("no wake in power-down");

    a_single_stops_en: assert property (
        timeout && ctrl_reg.single_interval |=> !ctrl_reg.interval_enable)
        else $error("single interval kept enable");

    a_reload_after_match: assert property (
        timeout && !ctrl_reg.single_interval |=>
        long_period_counter_reg == 8'h00 && ctrl_reg.interval_enable)
        else $error("auto reload failed");

    a_flag_sticky: assert property (
        ctrl_reg.interval_match_flag && !wr_ctrl |=> ctrl_reg.interval_match_flag)
        else $error("flag dropped without write");

    a_disable_zeroes: assert property (
        !ctrl_reg.interval_enable |=> long_period_counter_reg == 8'h00)
        else $error("counter not cleared when disabled");

    a_count_advance: assert property (
        ctrl_reg.interval_enable && sel_roll && !timeout |=>
        long_period_counter_reg == $past(long_period_counter_reg) + 8'h01)
        else $error("counter did not advance on rollover");

    a_sec_select: assert property (
        ctrl_reg.timebase_select == SEL_SECONDS && ctrl_reg.interval_enable &&
        !frac_ovf && !wr_ctrl |=> $stable(long_period_counter_reg))
        else $error("seconds select moved without rollover");

    a_tk_off_clears: assert property (tk_off |=> time_reg == '0 && presc_reg == '0)
        else $error("time registers not cleared");

    a_frac_step: assert property (
        tick && !frac_ovf && !tk_off |=> time_reg.fraction_tick_count ==
        $past(time_reg.fraction_tick_count) + 7'h01)
        else $error("fraction did not step");

    a_time_ranges: assert property (
        ctrl_reg.timekeeping_enable |-> time_reg.one_hz_count <= SEC_MAX &&
        time_reg.minutes <= MIN_MAX && time_reg.hours <= HOUR_MAX)
        else $error("time register out of range");

    a_day_wrap: assert property (min_ovf && time_reg.hours == HOUR_MAX |=>
        time_reg.hours == 5'h00 && time_reg.minutes == 6'h00)
        else $error("hours did not wrap");

    c_timeout_single: cover property (timeout && ctrl_reg.single_interval);
    c_timeout_reload: cover property (timeout ##1 ctrl_reg.interval_enable);
    c_wake: cover property (wake);
    c_minute_roll: cover property (sec_ovf);

endmodule // tivc_top

// file: logic/tivc_pkg.sv
package tivc_pkg;

    localparam logic [7:0]  ADDR_CTRL   = 8'hA1;
    localparam logic [7:0]  ADDR_FRAC   = 8'hA2;
    localparam logic [7:0]  ADDR_SEC    = 8'hA3;
    localparam logic [7:0]  ADDR_MIN    = 8'hA4;
    localparam logic [7:0]  ADDR_HOUR   = 8'hA5;
    localparam logic [7:0]  ADDR_LIMIT  = 8'hA6;

    localparam logic [5:0]  CTRL_RESET  = 6'h00;
    localparam logic [7:0]  LIMIT_RESET = 8'h00;
    localparam int          CTRL_BITS   = 6;

    localparam logic [6:0]  FRAC_MAX    = 7'h7F;
    localparam logic [5:0]  SEC_MAX     = 6'h3B;
    localparam logic [5:0]  MIN_MAX     = 6'h3B;
    localparam logic [4:0]  HOUR_MAX    = 5'h17;

    localparam logic [15:0] WAKE_VECTOR = 16'h0053;

    // One fraction tick is 1/128 s
    localparam longint      TICK_NS     = 64'd7812500;
    localparam longint      CLK_NS      = 64'd25;
    localparam int          TICK_CYCLES = int'(TICK_NS / CLK_NS);
    localparam int          PRESC_W     = 19;

    typedef enum logic [1:0] {
        SEL_FRACTION,
        SEL_SECONDS,
        SEL_MINUTES,
        SEL_HOURS
    } tivc_sel_t;

    // Bit order matches the control register, bits 5..0
    typedef struct packed {
        tivc_sel_t timebase_select;
        logic      single_interval;
        logic      interval_match_flag;
        logic      interval_enable;
        logic      timekeeping_enable;
    } tivc_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } tivc_sfr_req_t;

    typedef struct packed {
        logic [6:0] fraction_tick_count;
        logic [5:0] one_hz_count;
        logic [5:0] minutes;
        logic [4:0] hours;
    } tivc_time_t;

endpackage

// file: verification/time_interval_counter_tb_top.sv
`timescale 1ns/100ps
module time_interval_counter_tb_top;
    import tivc_pkg::*;

    // Short prescaler keeps every rollover reachable within a few hundred cycles
    localparam int TK = 4;

    logic           clk;
    logic           nrst;
    tivc_sfr_req_t  req;
    logic [7:0]     sfr_rdata;
    logic           int_enable;
    logic           power_down;
    logic           irq;
    logic           wake;
    logic [15:0]    wake_vector;
    int             fail_count;
    int             total_checks;

    tivc_top #(.TICK_CYCLES(TK)) u_dut (
        .clk         (clk),
        .nrst        (nrst),
        .sfr_req     (req),
        .sfr_rdata   (sfr_rdata),
        .int_enable  (int_enable),
        .power_down  (power_down),
        .irq         (irq),
        .wake        (wake),
        .wake_vector (wake_vector)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        req.addr  = a;
        req.wr    = 1'b1;
        req.wdata = d;
        @(posedge clk);
        #2;
        req.wr = 1'b0;
    endtask

    // Read data is registered, so it is sampled one edge after the address
    task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #2;
        req.addr = a;
        @(posedge clk);
        #2;
        check(n, {8'h00, sfr_rdata}, {8'h00, e});
    endtask

    // Writes control, then counts edges until the interrupt line rises
    task automatic go(input string n, input logic [7:0] c, input int e);
        int k;
        k = 0;
        wr(ADDR_CTRL, c);
        while (irq !== 1'b1 && k < 40) begin
            @(posedge clk);
            #2;
            k++;
        end
        check(n, 16'(k), 16'(e));
    endtask

    initial begin
        nrst       = 1'b0;
        req        = '0;
        int_enable = 1'b0;
        power_down = 1'b0;
        fail_count = 0;
        total_checks = 0;
        repeat (4) @(posedge clk);
        #2;
        nrst = 1'b1;
        for (int a = 8'hA0; a <= 8'hA7; a++) begin
            rd("reset_value", 8'(a), 8'h00);
        end
        check("vector", wake_vector, 16'h0053);
        $display("test reset done");

        wr(ADDR_FRAC, 8'h7E);
        wr(ADDR_SEC, 8'h3B);
        wr(ADDR_MIN, 8'h3B);
        wr(ADDR_HOUR, 8'h17);
        rd("frac_preset", ADDR_FRAC, 8'h7E);
        rd("hour_preset", ADDR_HOUR, 8'h17);
        wr(ADDR_CTRL, 8'h41);
        repeat (8) @(posedge clk);
        rd("frac_wrap", ADDR_FRAC, 8'h00);
        rd("sec_wrap", ADDR_SEC, 8'h00);
        rd("min_wrap", ADDR_MIN, 8'h00);
        rd("hour_wrap", ADDR_HOUR, 8'h00);
        wr(ADDR_SEC, 8'h11);
        rd("sec_locked", ADDR_SEC, 8'h00);
        rd("ctrl_resv", ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h00);
        rd("frac_clear", ADDR_FRAC, 8'h00);
        $display("test timekeeping done");

        int_enable = 1'b1;
        // Counting with power-down set lets the match drive the wake output
        power_down = 1'b1;
        wr(ADDR_LIMIT, 8'h02);
        rd("limit", ADDR_LIMIT, 8'h02);
        go("single", 8'h4B, 2 * TK);
        #1;
        check("wake", {15'h0000, wake}, 16'h0001);
        int_enable = 1'b0;
        #1;
        check("irq_masked", {15'h0000, irq}, 16'h0000);
        int_enable = 1'b1;
        repeat (20) @(posedge clk);
        rd("single_ctrl", ADDR_CTRL, 8'h0D);
        check("flag_held", {15'h0000, irq}, 16'h0001);
        wr(ADDR_CTRL, 8'h09);
        check("flag_clear", {15'h0000, irq}, 16'h0000);
        power_down = 1'b0;
        $display("test single done");

        wr(ADDR_CTRL, 8'h00);
        go("reload", 8'h03, 2 * TK);
        go("reload_next", 8'h03, 2 * TK - 2);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CTRL, 8'h03);
        repeat (4) @(posedge clk);
        wr(ADDR_CTRL, 8'h00);
        go("restart", 8'h03, 2 * TK);
        $display("test reload done");

        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CTRL, 8'h00);
            wr(ADDR_FRAC, 8'h7E);
            if (s >= 2) wr(ADDR_SEC, 8'h3B);
            if (s == 3) wr(ADDR_MIN, 8'h3B);
            wr(ADDR_LIMIT, 8'h01);
            go("select", {2'b01, 2'(s), 4'hB}, (s == 0) ? TK : 2 * TK);
        end
        wr(ADDR_CTRL, 8'h00);
        $display("test select done");
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

endmodule // time_interval_counter_tb_top
